// >>> design/floppy_pkg.sv
// Purpose: Constants and types for the floppy status and address registers.
// Assumes: APB slave, 32-bit data, one register per aligned word.
// Notes:   Summary of operation follows.
// Summary of operation
// R1: Data field checksum failure sets status bit 03 plus error and done.
// R2: Drive request unserved within one byte time sets bit 02, error, done.
// R3: Track or sector out of range sets bit 01 plus error and done.
// R4: Initialize finishing sets the initialize-complete bit 00.
// R5: Software loads track and sector before requesting a sector transfer.
// R6: Address bits 14-08 hold a track 0 to 114 octal; bit 15 zero.
// R7: Address bits 04-00 hold a sector 1 to 32 octal; bits 07-05 zero.
// R8: Completion interrupt requested only if the enable bit was already set.
// R9: Good initialize clears error and status, sets drive-ready and init bits.
// R10: Function end places the drive status word in the transfer buffer.
package floppy_pkg;
   localparam logic [7:0] CSR_OFS = 8'h00;
   localparam logic [7:0] BUF_OFS = 8'h04;
   localparam logic [7:0] TSA_OFS = 8'h08;
   localparam logic [7:0] DES_OFS = 8'h0c;
   localparam logic [7:0] IST_OFS = 8'h10;
   localparam logic [7:0] IMK_OFS = 8'h14;
   localparam int CS_ERR   = 15;
   localparam int CS_DONE  = 7;
   localparam int CS_IRQ   = 6;
   localparam int CS_GO    = 0;
   localparam int FN_LSB   = 1;
   localparam int DES_DRV  = 7;
   localparam int DES_CRC  = 3;
   localparam int DES_LOST = 2;
   localparam int DES_BAD  = 1;
   localparam int DES_INIT = 0;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR  = 1;
   localparam logic [2:0] FN_INIT   = 3'h4;
   localparam logic [2:0] FN_STATUS = 3'h5;
   localparam logic [6:0] MAX_TRACK  = 7'h4c;
   localparam logic [4:0] MIN_SECTOR = 5'h01;
   localparam logic [4:0] MAX_SECTOR = 5'h1a;
   localparam logic [7:0] DES_RESET  = 8'h00;
   localparam logic [7:0] DES_AFTER_INIT = 8'h81;
   localparam logic [1:0] IRQ_RESET  = 2'h0;
   localparam int CLK_NS       = 10;
   localparam int BYTE_TIME_NS = 32000;
   localparam int BYTE_CYCLES  = BYTE_TIME_NS / CLK_NS;
   localparam int INIT_TIME_NS = 20000;
   localparam int INIT_CYCLES  = (INIT_TIME_NS + CLK_NS - 1) / CLK_NS;
   typedef struct packed {
      logic drive_ready;
      logic crc_fail;
      logic data_req;
      logic op_done;
   } drive_pins_type;
   typedef struct packed {
      logic [6:0] track_number;
      logic [4:0] sector_number;
   } tsa_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_INIT = 3'b010,
      ST_XFER = 3'b100
   } state_type;
endpackage

// >>> design/floppy_status_and_address_regs.sv
// Purpose: Drive status, track/sector address and command registers on APB.
// Assumes: Drive pins are asynchronous; one clock pclk at 100 MHz.
// Notes:   An initialize runs automatically when reset is released.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module floppy_status_and_address_regs
   import floppy_pkg::*;
(
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [7:0]     paddr,
   input  wire logic [31:0]    pwdata,
   output logic      [31:0]    prdata,
   output logic                pready,
   output logic                pslverr,
   input  wire drive_pins_type drive_pins,
   output logic                func_start,
   output logic      [2:0]     func_code,
   output logic                irq
);
   state_type      state;
   drive_pins_type sync1;
   drive_pins_type sync2;
   drive_pins_type sync3;
   drive_pins_type pins;
   drive_pins_type pins_q;
   tsa_type        tsa;
   logic [7:0]     des;
   logic [15:0]    xbuf;
   logic           err;
   logic           done;
   logic           irq_allow;
   logic [15:0]    init_cnt;
   logic [11:0]    wait_cnt;
   logic           finish;
   logic           fail;
   logic [1:0]     ist;
   logic [1:0]     imk;
   logic [1:0]     next_ist;
   logic [31:0]    rd_mux;
   logic           mapped;
   logic           xfer_ok;
   logic           wr;
   logic           wr_csr;
   logic           start;
   logic           crc_evt;
   logic           done_evt;
   logic           overrun;
   logic           served;

   function automatic logic addr_ok(input tsa_type a);
      addr_ok = (a.track_number <= MAX_TRACK) &&
                (a.sector_number >= MIN_SECTOR) &&
                (a.sector_number <= MAX_SECTOR);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == CSR_OFS) || (a == BUF_OFS) || (a == TSA_OFS) ||
                  (a == DES_OFS) || (a == IST_OFS) || (a == IMK_OFS);
   endfunction

   // Each pin passes three flops; a change counts once the last two agree.
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1[i]  <= 1'b0;
               sync2[i]  <= 1'b0;
               sync3[i]  <= 1'b0;
               pins[i]   <= 1'b0;
               pins_q[i] <= 1'b0;
            end else begin
               sync1[i]  <= drive_pins[i];
               sync2[i]  <= sync1[i];
               sync3[i]  <= sync2[i];
               if (sync2[i] == sync3[i]) begin
                  pins[i] <= sync3[i];
               end
               pins_q[i] <= pins[i];
            end
         end
      end
   endgenerate

   assign crc_evt  = pins.crc_fail && !pins_q.crc_fail;
   assign done_evt = pins.op_done && !pins_q.op_done;

   // APB: one wait state, so every access answers two cycles after setup.
   assign xfer_ok = psel && penable && pready;
   assign wr      = xfer_ok && pwrite && mapped;
   assign wr_csr  = wr && (paddr == CSR_OFS);
   assign start   = wr_csr && pwdata[CS_GO];
   assign served  = xfer_ok && (paddr == BUF_OFS);
   assign mapped  = is_mapped(paddr);
   assign overrun = pins.data_req && (wait_cnt == 12'(BYTE_CYCLES - 1));

   always_comb begin
      case (paddr)
         CSR_OFS: rd_mux = {16'h0000, err, 7'h00, done, irq_allow,
                            2'h0, func_code, 1'b0};
         BUF_OFS: rd_mux = {16'h0000, xbuf};
         TSA_OFS: rd_mux = {16'h0000, 1'b0, tsa.track_number, 3'h0,
                            tsa.sector_number};                    // [R6] [R7]
         DES_OFS: rd_mux = {24'h000000, des};
         IST_OFS: rd_mux = {30'h00000000, ist};
         IMK_OFS: rd_mux = {30'h00000000, imk};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (psel && penable && !pready) begin
            prdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tsa <= '0;
      end else if (wr && (paddr == TSA_OFS)) begin
         tsa.track_number  <= pwdata[14:8];                          // [R6]
         tsa.sector_number <= pwdata[4:0];                           // [R7]
      end
   end

   // The wait restarts whenever software touches the transfer buffer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt <= 12'h000;
      end else if (state != ST_XFER || !pins.data_req || served) begin
         wait_cnt <= 12'h000;
      end else if (!overrun) begin
         wait_cnt <= wait_cnt + 12'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= ST_INIT;
         err        <= 1'b0;
         done       <= 1'b0;
         irq_allow  <= 1'b0;
         des        <= DES_RESET;
         init_cnt   <= 16'h0000;
         func_code  <= FN_INIT;
         func_start <= 1'b0;
         finish     <= 1'b0;
         fail       <= 1'b0;
      end else begin
         finish     <= 1'b0;
         fail       <= 1'b0;
         func_start <= 1'b0;
         if (wr_csr) begin
            irq_allow <= pwdata[CS_IRQ];
         end
         case (state)
            ST_IDLE: begin
               if (start) begin
                  func_code <= pwdata[FN_LSB +: 3];
                  done      <= 1'b0;
                  err       <= 1'b0;
                  if (pwdata[FN_LSB +: 3] == FN_INIT) begin
                     init_cnt   <= 16'h0000;
                     func_start <= 1'b1;
                     state      <= ST_INIT;
                  end else if (pwdata[FN_LSB +: 3] == FN_STATUS) begin
                     des[DES_DRV] <= pins.drive_ready;
                     done         <= 1'b1;
                     finish       <= 1'b1;
                  end else if (!pins.drive_ready) begin
                     err    <= 1'b1;
                     done   <= 1'b1;
                     finish <= 1'b1;
                     fail   <= 1'b1;
                  end else if (!addr_ok(tsa)) begin                // [R5]
                     des[DES_BAD] <= 1'b1;                         // [R3]
                     err          <= 1'b1;
                     done         <= 1'b1;
                     finish       <= 1'b1;
                     fail         <= 1'b1;
                  end else begin
                     des[DES_CRC]  <= 1'b0;
                     des[DES_LOST] <= 1'b0;
                     des[DES_BAD]  <= 1'b0;
                     func_start    <= 1'b1;
                     state         <= ST_XFER;
                  end
               end
            end
            ST_INIT: begin
               done <= 1'b0;
               if (init_cnt == 16'(INIT_CYCLES - 1)) begin
                  des    <= DES_AFTER_INIT;                        // [R4] [R9]
                  des[DES_DRV] <= pins.drive_ready;                // [R9]
                  err    <= 1'b0;                                  // [R9]
                  done   <= 1'b1;
                  finish <= 1'b1;
                  state  <= ST_IDLE;
               end else begin
                  init_cnt <= init_cnt + 16'h0001;
               end
            end
            ST_XFER: begin
               if (crc_evt) begin
                  des[DES_CRC] <= 1'b1;                            // [R1]
                  err          <= 1'b1;
                  done         <= 1'b1;
                  finish       <= 1'b1;
                  fail         <= 1'b1;
                  state        <= ST_IDLE;
               end else if (overrun) begin
                  des[DES_LOST] <= 1'b1;                           // [R2]
                  err           <= 1'b1;
                  done          <= 1'b1;
                  finish        <= 1'b1;
                  fail          <= 1'b1;
                  state         <= ST_IDLE;
               end else if (done_evt) begin
                  done   <= 1'b1;
                  finish <= 1'b1;
                  state  <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Status lands in the buffer one cycle after done, before any read ends.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xbuf <= 16'h0000;
      end else if (finish) begin
         xbuf <= {8'h00, des};                                     // [R10]
      end else if (wr && (paddr == BUF_OFS)) begin
         xbuf <= pwdata[15:0];
      end
   end

   // A hardware set in the same cycle as a write-one clear wins.
   always_comb begin
      next_ist = ist;
      if (wr && (paddr == IST_OFS)) begin
         next_ist = ist & ~pwdata[1:0];
      end
      if (finish && irq_allow) begin
         next_ist[IRQ_DONE] = 1'b1;                                // [R8]
      end
      if (fail && irq_allow) begin
         next_ist[IRQ_ERR] = 1'b1;                                 // [R8]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist <= IRQ_RESET;
         imk <= IRQ_RESET;
         irq <= 1'b0;
      end else begin
         ist <= next_ist;
         if (wr && (paddr == IMK_OFS)) begin
            imk <= pwdata[1:0];
         end
         irq <= |(ist & imk);
      end
   end

   chk_crc_flag: assert property (@(posedge pclk)                    // [R1]
      disable iff (!presetn)
      (state == ST_XFER && crc_evt) |=> (des[DES_CRC] && err && done))
      else $error("checksum failure did not raise flag, error and done");

   chk_lost_flag: assert property (@(posedge pclk)                   // [R2]
      disable iff (!presetn)
      (state == ST_XFER && !crc_evt && overrun)
      |=> (des[DES_LOST] && err && done && state == ST_IDLE))
      else $error("unserved drive request did not raise lost flag");

   chk_bad_address: assert property (@(posedge pclk)                 // [R3]
      disable iff (!presetn)
      (state == ST_IDLE && start && pins.drive_ready && !addr_ok(tsa) &&
       pwdata[FN_LSB +: 3] != FN_INIT && pwdata[FN_LSB +: 3] != FN_STATUS)
      |=> (des[DES_BAD] && err && done && state == ST_IDLE))
      else $error("bad address did not raise flag, error and done");

   chk_init_done: assert property (@(posedge pclk)                   // [R4]
      disable iff (!presetn)
      (state == ST_INIT && init_cnt == 16'(INIT_CYCLES - 1))
      |=> (des[DES_INIT] && done && finish))
      else $error("initialize did not set its completion bit");

   chk_track_write: assert property (@(posedge pclk)                 // [R6]
      disable iff (!presetn)
      (wr && paddr == TSA_OFS) |=> (tsa.track_number == $past(pwdata[14:8])))
      else $error("track number not stored");

   chk_sector_write: assert property (@(posedge pclk)                // [R7]
      disable iff (!presetn)
      (wr && paddr == TSA_OFS) |=> (tsa.sector_number == $past(pwdata[4:0])))
      else $error("sector number not stored");

   chk_irq_gate: assert property (@(posedge pclk)                    // [R8]
      disable iff (!presetn)
      $rose(ist[IRQ_ERR]) |-> ($past(irq_allow) && $past(fail)))
      else $error("error interrupt raised without prior enable");

   chk_init_clear: assert property (@(posedge pclk)                  // [R9]
      disable iff (!presetn)
      (state == ST_INIT && init_cnt == 16'(INIT_CYCLES - 1))
      |=> (!err && des[6:1] == 6'h00 ##1 xbuf[DES_INIT]))
      else $error("initialize did not clear error and status");

   chk_status_buf: assert property (@(posedge pclk)                  // [R10]
      disable iff (!presetn)
      finish |=> (xbuf == {8'h00, $past(des)}))
      else $error("status word not placed in transfer buffer");

   chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> (pready ##1 !pready))
      else $error("apb answer not given after one wait state");

   chk_irq_level: assert property (@(posedge pclk)                   // [R8]
      disable iff (!presetn)
      irq == $past(|(ist & imk)))
      else $error("interrupt output does not follow unmasked status");

   chk_init_start: assert property (@(posedge pclk)                  // [R4]
      disable iff (!presetn)
      (state == ST_IDLE && start && pwdata[FN_LSB +: 3] == FN_INIT)
      |=> (!done && !err && state == ST_INIT && func_start))
      else $error("initialize start did not clear done and error");

   chk_bad_no_start: assert property (@(posedge pclk)                // [R3]
      disable iff (!presetn)
      (state == ST_IDLE && start && !addr_ok(tsa) &&
       pwdata[FN_LSB +: 3] != FN_INIT && pwdata[FN_LSB +: 3] != FN_STATUS)
      |=> !func_start)
      else $error("bad address still started the drive");
endmodule

// >>> testbench/floppy_drive_model.sv
// Purpose: Behavioural floppy drive that faces the status and address block.
// Assumes: The bench picks the drive's reply with mode before each start.
// Notes:   Modes: 0 finish soon, 1 finish late, 2 checksum fault, 3 stall.
`timescale 1ns/100ps
module floppy_drive_model
   import floppy_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       func_start,
   input  wire logic [2:0] func_code,
   input  wire logic [1:0] mode,
   input  wire logic       ready,
   output drive_pins_type  drive_pins
);
   logic crc;
   logic req;
   logic fin;
   int   n;
   assign drive_pins = '{ready, crc, req, fin};
   // Pulses last eight cycles so the block's pin synchronisers see them.
   initial begin
      crc = 1'b0;
      req = 1'b0;
      fin = 1'b0;
      forever begin
         @(posedge pclk);
         if (func_start && func_code != FN_INIT
             && func_code != FN_STATUS) begin
            repeat (mode == 2'h1 ? 40 : 5) @(posedge pclk);
            if (mode == 2'h3) begin
               req <= 1'b1;
               n = 0;
               // An unserved request is held until a new function begins or BYTE_CYCLES + 200 cycles pass.
               while (n < BYTE_CYCLES + 200 && !func_start) begin
                  @(posedge pclk);
                  n++;
               end
            end else begin
               crc <= (mode == 2'h2);
               fin <= (mode != 2'h2);
               repeat (8) @(posedge pclk);
            end
            crc <= 1'b0;
            req <= 1'b0;
            fin <= 1'b0;
         end
      end
   end
endmodule

// >>> testbench/test_floppy_status_and_address_regs.sv
// Purpose: Self-checking bench for the floppy status and address registers.
// Assumes: APB master tasks; one bench clock of 100 MHz.
// Notes:   The two initializes and the stall path dominate the run.
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module test_floppy_status_and_address_regs
   import floppy_pkg::*;
;
   logic           pclk;
   logic           presetn;
   logic           psel;
   logic           penable;
   logic           pwrite;
   logic [7:0]     paddr;
   logic [31:0]    pwdata;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   drive_pins_type drive_pins;
   logic           func_start;
   logic [2:0]     func_code;
   logic           irq;
   logic [1:0]     mode;
   logic           ready;
   logic [31:0]    rd;
   logic           er;
   int             n_mismatch;
   int             cmp_count;
   logic [15:0]    tsa_tab [5] = '{16'h4d01, 16'h4c00, 16'h4c1b,
                                   16'h0101, 16'h0101};
   logic [1:0]     mode_tab [5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h3};
   logic [2:0]     flag_tab [5] = '{3'h1, 3'h1, 3'h1, 3'h4, 3'h2};
   floppy_status_and_address_regs DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .drive_pins(drive_pins),
      .func_start(func_start), .func_code(func_code), .irq(irq));
   floppy_drive_model drive (.pclk(pclk), .func_start(func_start),
      .func_code(func_code), .mode(mode), .ready(ready),
      .drive_pins(drive_pins));
   always #5 pclk = ~pclk;
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) `CHK(1'b0, 1'b1)
   endtask
   // Polls done; the stall case needs over 3200 cycles.
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         apb(1'b0, CSR_OFS, 32'h0);
         n++;
      end while (rd[CS_DONE] !== 1'b1 && n < 2000);
      if (n >= 2000) `CHK(1'b0, 1'b1)
   endtask
   task automatic run(input logic [2:0] fn, input logic ie);
      apb(1'b1, CSR_OFS, {25'h0, ie, 2'h0, fn, 1'b1});
      wait_done();
   endtask
   initial begin
      #500000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; mode = 2'h0;
      ready = 1'b1; n_mismatch = 0; cmp_count = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      wait_done();
      `CHK(rd[CS_ERR], 1'b0)
      apb(1'b0, DES_OFS, 32'h0);
      `CHK(rd, 32'h00000081)
      apb(1'b1, TSA_OFS, 32'hffffffff);
      apb(1'b0, TSA_OFS, 32'h0);
      `CHK(rd, 32'h00007f1f)
      apb(1'b0, 8'h40, 32'h0);
      `CHK(er, 1'b1)
      apb(1'b1, IMK_OFS, 32'h3);
      apb(1'b1, TSA_OFS, 32'h4c1a);
      mode <= 2'h1;
      run(3'h0, 1'b1);
      `CHK(rd[15:0], 16'h00c0)
      apb(1'b0, IST_OFS, 32'h0);
      `CHK(rd[1:0], 2'h1)
      `CHK(irq, 1'b1)
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, TSA_OFS, {16'h0, tsa_tab[i]});
         mode <= mode_tab[i];
         run(3'h0, i != 3);
         `CHK(rd[15:0], (i != 3) ? 16'h80c0 : 16'h8080)
         apb(1'b0, DES_OFS, 32'h0);
         `CHK(rd[3:1], flag_tab[i])
         apb(1'b0, BUF_OFS, 32'h0);
         `CHK(rd[3:1], flag_tab[i])
         apb(1'b0, IST_OFS, 32'h0);
         `CHK(rd[1:0], (i != 3) ? 2'h3 : 2'h0)
         `CHK(irq, (i != 3) ? 1'b1 : 1'b0)
         apb(1'b1, IST_OFS, 32'h3);
         apb(1'b0, IST_OFS, 32'h0);
         `CHK(rd[1:0], 2'h0)
         `CHK(irq, 1'b0)
      end
      ready <= 1'b0;
      apb(1'b1, IMK_OFS, 32'h0);
      run(FN_STATUS, 1'b1);
      `CHK(func_code, FN_STATUS)
      apb(1'b0, BUF_OFS, 32'h0);
      `CHK(rd[7:0], 8'h05)
      `CHK(irq, 1'b0)
      run(3'h1, 1'b0);
      `CHK(rd[15:0], 16'h8082)
      ready <= 1'b1;
      run(FN_INIT, 1'b0);
      `CHK(rd[CS_ERR], 1'b0)
      apb(1'b0, DES_OFS, 32'h0);
      `CHK(rd, 32'h00000081)
      end_sim();
   end
endmodule
